// ---- bench/lane_rx_model.sv ----
// Receiver model on the lane side: sorts each link step into pattern or data.
// Assumes lane outputs settle between link clock rises.
`timescale 1ns/10ps
module lane_rx_model (
   input wire logic link_clk,
   input wire logic [7:0] lane_data,
   input wire logic [3:0] lane_hs,
   output int cal55_cnt,
   output int calaa_cnt,
   output int data_cnt,
   output int cal_first,
   output logic [3:0] last_mask,
   output logic [7:0] last_byte
);
   // One process owns every count
   initial begin
      cal55_cnt = 0;
      calaa_cnt = 0;
      data_cnt = 0;
      cal_first = -1;
      last_mask = 4'h0;
      last_byte = 8'h00;
      forever begin
         // Sampled at the rise, when the previous step has settled
         @(posedge link_clk);
         if (lane_hs !== 4'h0) begin
            if (lane_data === csi_tx_pkg::CAL_PAT) begin
               cal55_cnt++;
            end else if (lane_data === csi_tx_pkg::CAL_PAT_INV) begin
               calaa_cnt++;
            end else begin
               if (data_cnt == 0) begin
                  cal_first = cal55_cnt;
               end
               data_cnt++;
               last_mask = lane_hs;
               last_byte = lane_data;
            end
         end
      end
   end
endmodule

// ---- bench/tb.sv ----
// Testbench of the transmit output control: AHB-Lite register tasks and stream pushes.
// Assumes the lane receiver model watches the lane outputs.
`timescale 1ns/10ps
module tb;
   logic clk, reset_n, hsel, hwrite, link_clk, in_valid, in_start, in_frame_end;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] in_data, lane_data, last_byte;
   logic hreadyout, hresp, in_ready, clk_hs, clk_lp00, dup_clk_hs;
   logic [3:0] lane_hs, lane_lp00, last_mask;
   int error_cnt, n_checks, cal55_cnt, calaa_cnt, data_cnt, cal_first;
   localparam logic [31:0] A_CTRL = {22'h0, csi_tx_pkg::CTRL_IDX, 2'b00};
   localparam logic [31:0] A_CTRL2 = {22'h0, csi_tx_pkg::CTRL2_IDX, 2'b00};
   localparam logic [31:0] A_DUP = {22'h0, csi_tx_pkg::DUP_IDX, 2'b00};
   localparam logic [31:0] A_STAT = {22'h0, csi_tx_pkg::STAT_IDX, 2'b00};
   logic [3:0] mask_tab [4] = '{4'hF, 4'h7, 4'h3, 4'h1};
   logic [1:0] ulp_tab [3] = '{2'h1, 2'h3, 2'h2};
   logic [3:0] lp_tab [3] = '{4'hF, 4'hF, 4'h0};
   logic clp_tab [3] = '{1'b0, 1'b1, 1'b0};

   csi_tx_ctrl dut_u (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link_clk(link_clk),
      .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .in_start(in_start),
      .in_frame_end(in_frame_end), .lane_data(lane_data), .lane_hs(lane_hs),
      .lane_lp00(lane_lp00), .clk_hs(clk_hs), .clk_lp00(clk_lp00), .dup_clk_hs(dup_clk_hs));

   lane_rx_model rx_u (.link_clk(link_clk), .lane_data(lane_data), .lane_hs(lane_hs),
      .cal55_cnt(cal55_cnt), .calaa_cnt(calaa_cnt), .data_cnt(data_cnt),
      .cal_first(cal_first), .last_mask(last_mask), .last_byte(last_byte));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #160 link_clk = ~link_clk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic timed_out();
      error_cnt++;
      $display("wrong value at %0t: wait ran out", $time);
      conclude();
   endtask

   // Samples hready at each rising edge, before that edge's updates land
   task automatic wait_ready();
      int i;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (hreadyout === 1'b1) break;
      end
      if (i == 50) timed_out();
   endtask

   task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= addr;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask

   task automatic rdc(input logic [31:0] addr, input logic [31:0] exp, input string msg);
      bus(1'b0, addr, 32'h0000_0000);
      check(rd, exp, msg);
   endtask

   task automatic push(input logic [7:0] b, input logic fe);
      int i;
      @(posedge clk);
      in_valid <= 1'b1;
      in_data <= b;
      in_frame_end <= fe;
      for (i = 0; i < 50; i++) begin
         @(negedge clk);
         if (in_ready === 1'b1) break;
      end
      if (i == 50) timed_out();
      @(posedge clk);
      in_valid <= 1'b0;
   endtask

   task automatic wait_for(input int which, input int target);
      int i;
      int v;
      for (i = 0; i < 2000; i++) begin
         @(negedge clk);
         v = (which == 0) ? data_cnt : (which == 1) ? cal55_cnt : calaa_cnt;
         if (v >= target) break;
      end
      if (i == 2000) timed_out();
   endtask

   task automatic end_test(input string name);
      $display("test %s done, mismatches so far %0d", name, error_cnt);
   endtask

   initial begin
      error_cnt = 0;
      n_checks = 0;
      reset_n = 1'b0;
      {hsel, hwrite, in_valid, in_frame_end} = 4'h0;
      in_start = 1'b1;
      {haddr, hwdata} = 64'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      in_data = 8'h00;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      rdc(A_CTRL, 32'h0000_0000, "control reset");
      rdc(A_CTRL2, 32'h0000_0040, "control two reset");
      rdc(32'h0000_0100, 32'h0000_0000, "unmapped read");
      check(lane_hs, 32'h0000_0000, "lanes idle at reset");
      check(hresp, 32'h0000_0000, "response okay");
      end_test("reset");
      push(8'h11, 1'b0);
      push(8'h22, 1'b0);
      repeat (2) @(negedge clk);
      check(in_ready, 32'h0000_0000, "buffer full refuses");
      check(data_cnt, 32'h0000_0000, "no data while off");
      bus(1'b1, A_CTRL, 32'h0000_0063);
      wait_for(0, 2);
      check(cal_first, 32'h0000_0010, "skew before data");
      check(cal55_cnt, 32'h0000_0010, "skew pattern length");
      check(last_byte, 32'h0000_0022, "buffered order");
      check(last_mask, 32'h0000_0003, "two lanes");
      repeat (16) @(negedge clk);
      check(clk_hs, 32'h0000_0001, "clock keeps running");
      end_test("initial skew");
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, A_CTRL, 32'h0000_0001 | (k << 4));
         push(8'h30 + k[7:0], 1'b0);
         wait_for(0, 3 + k);
         check(last_mask, {28'h0, mask_tab[k]}, "lane mask");
      end
      end_test("lane count");
      for (int k = 0; k < 3; k++) begin
         bus(1'b1, A_CTRL, 32'h0000_0001 | (ulp_tab[k] << 2));
         repeat (4) @(negedge clk);
         check(lane_lp00, {28'h0, lp_tab[k]}, "data lanes forced");
         check(clk_lp00, {31'h0, clp_tab[k]}, "clock lane forced");
      end
      bus(1'b1, A_CTRL, 32'h0000_0001);
      end_test("low power");
      bus(1'b1, A_CTRL2, 32'h0000_0006);
      wait_for(2, 16);
      repeat (16) @(negedge clk);
      check(calaa_cnt, 32'h0000_0010, "inverted single sequence");
      rdc(A_CTRL2, 32'h0000_0044, "single request cleared");
      end_test("single skew");
      bus(1'b1, A_CTRL2, 32'h0000_0001);
      push(8'h44, 1'b1);
      wait_for(1, 32);
      repeat (16) @(negedge clk);
      check(data_cnt, 32'h0000_0007, "data before periodic skew");
      check(cal55_cnt, 32'h0000_0020, "periodic sequence");
      end_test("periodic skew");
      bus(1'b1, A_DUP, 32'h0000_0001);
      bus(1'b1, A_CTRL, 32'h0000_0003);
      push(8'h66, 1'b0);
      wait_for(0, 8);
      check(last_mask, 32'h0000_0003, "duplication clamps lanes");
      check(dup_clk_hs, 32'h0000_0001, "copy clock runs");
      bus(1'b0, A_STAT, 32'h0000_0000);
      check(rd & 32'h0000_0040, 32'h0000_0040, "illegal count flagged");
      end_test("duplication");
      bus(1'b1, A_CTRL, 32'h0000_0000);
      repeat (4) @(negedge clk);
      check(lane_hs, 32'h0000_0000, "lanes stop when off");
      check(clk_hs, 32'h0000_0000, "clock stops when off");
      check(dup_clk_hs, 32'h0000_0000, "copy clock stops");
      rdc(A_CTRL, 32'h0000_0000, "control cleared");
      end_test("disable");
      conclude();
   end
endmodule

// ---- rtl/csi_tx_ctrl.sv ----
// Transmit output control for the serial video port, with AHB-Lite registers.
// Assumes an upstream byte stream on clk and a link clock from outside.
`timescale 1ns/10ps
module csi_tx_ctrl (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic link_clk,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [7:0] in_data,
   input wire logic in_start,
   input wire logic in_frame_end,
   output logic [7:0] lane_data,
   output logic [3:0] lane_hs,
   output logic [3:0] lane_lp00,
   output logic clk_hs,
   output logic clk_lp00,
   output logic dup_clk_hs
);
   csi_tx_pkg::tx_state_e state_ff;
   csi_tx_pkg::tx_state_e nxt_state;
   logic tick;
   stream_if up ();
   stream_if dn ();

   // Bus slave state
   logic hreadyout_ff;
   logic [31:0] hrdata_ff;
   logic hresp_ff;
   logic wr_pend_ff;
   logic rd_pend_ff;
   logic [7:0] idx_ff;
   logic idx_ok_ff;

   // Control registers
   logic [6:0] ctrl_ff;
   logic per_ff;
   logic single_ff;
   logic inv_ff;
   logic dup_ff;
   logic nxt_single;

   // Transmit state
   logic [7:0] cal_cnt_ff;
   logic cal_single_ff;
   logic first_seen_ff;
   logic lane_err_ff;
   logic sending_ff;
   logic [7:0] lane_data_ff;
   logic [3:0] lane_hs_ff;
   logic [3:0] lane_lp00_ff;
   logic clk_hs_ff;
   logic clk_lp00_ff;
   logic dup_clk_hs_ff;

   link_sampler u_link (
      .clk(clk),
      .reset_n(reset_n),
      .link_clk(link_clk),
      .tick(tick)
   );

   pair_buffer u_buf (
      .clk(clk),
      .reset_n(reset_n),
      .wr(up),
      .rd(dn)
   );

   assign up.valid = in_valid;
   assign up.data = {in_start, in_frame_end, in_data};
   assign in_ready = up.ready;

   // Address phase decode
   logic accept;
   logic addr_ok;
   assign accept = hsel && htrans[1] && hready;
   assign addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);

   // Register selects in the data phase
   logic wr_ctrl;
   logic wr_ctrl2;
   logic wr_dup;
   logic [31:0] rdata;
   assign wr_ctrl = wr_pend_ff && idx_ok_ff && (idx_ff == csi_tx_pkg::CTRL_IDX);
   assign wr_ctrl2 = wr_pend_ff && idx_ok_ff && (idx_ff == csi_tx_pkg::CTRL2_IDX);
   assign wr_dup = wr_pend_ff && idx_ok_ff && (idx_ff == csi_tx_pkg::DUP_IDX);
   assign rdata = !idx_ok_ff ? 32'h0 :
      (idx_ff == csi_tx_pkg::CTRL_IDX) ? {25'h0, ctrl_ff} :
      (idx_ff == csi_tx_pkg::CTRL2_IDX) ?
         {24'h0, csi_tx_pkg::CTRL2_RSVD, 1'b0, inv_ff, single_ff, per_ff} :
      (idx_ff == csi_tx_pkg::DUP_IDX) ? {31'h0, dup_ff} :
      (idx_ff == csi_tx_pkg::STAT_IDX) ? {25'h0, lane_err_ff, first_seen_ff, state_ff} :
      32'h0;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         idx_ff <= 8'h0;
         idx_ok_ff <= 1'b0;
         hreadyout_ff <= 1'b1;
         hrdata_ff <= 32'h0;
         hresp_ff <= 1'b0;
      end else begin
         wr_pend_ff <= accept && hwrite;
         rd_pend_ff <= accept && !hwrite;
         hreadyout_ff <= !(accept && !hwrite);
         if (accept) begin
            idx_ff <= haddr[9:2];
            idx_ok_ff <= addr_ok;
         end
         if (rd_pend_ff) begin
            hrdata_ff <= rdata;
         end
      end
   end

   assign hreadyout = hreadyout_ff;
   assign hrdata = hrdata_ff;
   assign hresp = hresp_ff;

   // Control field views
   logic en;
   logic cont;
   logic cal_en;
   logic [1:0] ulp;
   logic [1:0] lane_code;
   logic [1:0] lane_sel;
   logic [3:0] lane_mask;
   logic data_forced;
   logic clk_forced;
   assign en = ctrl_ff[csi_tx_pkg::EN_BIT];
   assign cont = ctrl_ff[csi_tx_pkg::CONT_BIT];
   assign cal_en = ctrl_ff[csi_tx_pkg::CALEN_BIT];
   assign ulp = ctrl_ff[csi_tx_pkg::ULP_LSB +: 2];
   assign lane_code = ctrl_ff[csi_tx_pkg::LANE_LSB +: 2];
   // Duplicated output limits the port to two lanes
   assign lane_sel = (dup_ff && !lane_code[1]) ? csi_tx_pkg::LANE_TWO : lane_code;
   assign lane_mask = csi_tx_pkg::LANE_ALL >> lane_sel;
   assign data_forced = (ulp == csi_tx_pkg::ULP_DATA) || (ulp == csi_tx_pkg::ULP_ALL);
   assign clk_forced = (ulp == csi_tx_pkg::ULP_ALL);

   // Link step and stream consumption
   logic step;
   logic pop;
   logic cal_state;
   logic cal_done;
   logic hw_clear;
   logic clk_on;
   logic [7:0] pattern;
   assign step = tick && en && !data_forced;
   assign cal_state = (state_ff == csi_tx_pkg::ST_INIT_CAL) || (state_ff == csi_tx_pkg::ST_CAL);
   assign pop = step && (state_ff == csi_tx_pkg::ST_DATA) && dn.valid;
   assign dn.ready = pop;
   assign cal_done = step && cal_state && (cal_cnt_ff == csi_tx_pkg::CAL_LAST);
   assign hw_clear = cal_done && cal_single_ff;
   assign pattern = inv_ff ? csi_tx_pkg::CAL_PAT_INV : csi_tx_pkg::CAL_PAT;
   // Lanes show high speed only for a step that sent a byte, never a stale one
   logic sent;
   logic lane_on;
   assign sent = pop || (step && cal_state);
   assign lane_on = en && !data_forced && (step ? sent : sending_ff);
   assign clk_on = en && !clk_forced &&
      ((state_ff == csi_tx_pkg::ST_DATA) || cal_state || (cont && first_seen_ff));
   // Software write wins over the self-clear
   assign nxt_single = wr_ctrl2 ? hwdata[csi_tx_pkg::SINGLE_BIT] : (single_ff && !hw_clear);

   always_comb begin
      nxt_state = state_ff;
      if (!en) begin
         nxt_state = csi_tx_pkg::ST_OFF;
      end else if (step) begin
         case (state_ff)
            csi_tx_pkg::ST_OFF: begin
               nxt_state = cal_en ? csi_tx_pkg::ST_INIT_CAL : csi_tx_pkg::ST_IDLE;
            end
            csi_tx_pkg::ST_INIT_CAL, csi_tx_pkg::ST_CAL: begin
               if (cal_cnt_ff == csi_tx_pkg::CAL_LAST) begin
                  nxt_state = csi_tx_pkg::ST_IDLE;
               end
            end
            csi_tx_pkg::ST_IDLE: begin
               if (single_ff) begin
                  nxt_state = csi_tx_pkg::ST_CAL;
               end else if (dn.valid) begin
                  nxt_state = csi_tx_pkg::ST_DATA;
               end
            end
            csi_tx_pkg::ST_DATA: begin
               if (pop && dn.data[csi_tx_pkg::FE_BIT]) begin
                  nxt_state = per_ff ? csi_tx_pkg::ST_CAL : csi_tx_pkg::ST_IDLE;
               end else if (!dn.valid) begin
                  nxt_state = csi_tx_pkg::ST_IDLE;
               end
            end
            default: begin
               nxt_state = csi_tx_pkg::ST_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_ff <= csi_tx_pkg::CTRL_RESET;
         per_ff <= 1'b0;
         single_ff <= 1'b0;
         inv_ff <= 1'b0;
         dup_ff <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= hwdata[6:0];
         end
         if (wr_ctrl2) begin
            per_ff <= hwdata[csi_tx_pkg::PER_BIT];
            inv_ff <= hwdata[csi_tx_pkg::INV_BIT];
         end
         if (wr_dup) begin
            dup_ff <= hwdata[csi_tx_pkg::DUP_BIT];
         end
         single_ff <= nxt_single;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= csi_tx_pkg::ST_OFF;
         cal_cnt_ff <= 8'h0;
         cal_single_ff <= 1'b0;
         first_seen_ff <= 1'b0;
         lane_err_ff <= 1'b0;
         sending_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cal_cnt_ff <= !cal_state ? 8'h0 : (step ? 8'(cal_cnt_ff + 8'h1) : cal_cnt_ff);
         if (step && (state_ff == csi_tx_pkg::ST_IDLE) && single_ff) begin
            cal_single_ff <= 1'b1;
         end else if (cal_done || !en) begin
            cal_single_ff <= 1'b0;
         end
         first_seen_ff <= en && (first_seen_ff || pop);
         lane_err_ff <= dup_ff && !lane_code[1];
         sending_ff <= lane_on;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lane_data_ff <= 8'h0;
         lane_hs_ff <= 4'h0;
         lane_lp00_ff <= 4'h0;
         clk_hs_ff <= 1'b0;
         clk_lp00_ff <= 1'b0;
         dup_clk_hs_ff <= 1'b0;
      end else begin
         if (pop) begin
            lane_data_ff <= dn.data[7:0];
         end else if (step && cal_state) begin
            lane_data_ff <= pattern;
         end
         lane_hs_ff <= lane_on ? lane_mask : 4'h0;
         lane_lp00_ff <= (en && data_forced) ? csi_tx_pkg::LANE_ALL : 4'h0;
         clk_hs_ff <= clk_on;
         clk_lp00_ff <= en && clk_forced;
         dup_clk_hs_ff <= clk_on && dup_ff;
      end
   end

   assign lane_data = lane_data_ff;
   assign lane_hs = lane_hs_ff;
   assign lane_lp00 = lane_lp00_ff;
   assign clk_hs = clk_hs_ff;
   assign clk_lp00 = clk_lp00_ff;
   assign dup_clk_hs = dup_clk_hs_ff;

   default clocking dflt @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_off_quiet: assert property (
      !en |=> lane_hs == 4'h0 && !clk_hs && !dup_clk_hs)
      else $error("lane activity while output disabled");
   a_lane_mask: assert property (
      1'b1 |=> (lane_hs & ~$past(lane_mask)) == 4'h0)
      else $error("inactive lane driven");
   a_dup_limit: assert property (
      dup_ff && en && !data_forced && (state_ff == csi_tx_pkg::ST_DATA) |=> lane_hs[3:2] == 2'h0)
      else $error("duplicated output uses more than two lanes");
   a_ulp_data: assert property (
      en && (ulp == csi_tx_pkg::ULP_DATA) |=> lane_lp00 == 4'hF && lane_hs == 4'h0
         && !clk_lp00)
      else $error("data lanes not forced low");
   a_ulp_clock: assert property (
      en && (ulp == csi_tx_pkg::ULP_ALL) |=> clk_lp00 && !clk_hs)
      else $error("clock lane not forced low");
   a_cont_clock: assert property (
      en && cont && first_seen_ff && !clk_forced |=> clk_hs)
      else $error("continuous clock stopped");
   a_init_cal: assert property (
      (state_ff == csi_tx_pkg::ST_OFF) && step && cal_en |=>
         state_ff == csi_tx_pkg::ST_INIT_CAL ##1 !pop [*8])
      else $error("data before initial skew sequence");
   a_cal_pattern: assert property (
      step && cal_state |=> lane_data == ($past(inv_ff) ? 8'hAA : 8'h55))
      else $error("wrong skew pattern");
   a_single_clear: assert property (
      $fell(single_ff) |-> $past(wr_ctrl2) || $past(cal_done && cal_single_ff))
      else $error("single request cleared without a sequence");
   a_periodic_fe: assert property (
      pop && dn.data[csi_tx_pkg::FE_BIT] && per_ff |=> state_ff == csi_tx_pkg::ST_CAL)
      else $error("no skew sequence after frame end");
   a_read_wait: assert property (
      accept && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read answer timing broken");

   c_init_cal: cover property (cal_done && (state_ff == csi_tx_pkg::ST_INIT_CAL));
   c_periodic: cover property (pop && dn.data[csi_tx_pkg::FE_BIT] && per_ff);
   c_single: cover property (hw_clear);
   c_cont_clk: cover property (clk_hs && (state_ff == csi_tx_pkg::ST_IDLE));
endmodule

// ---- rtl/csi_tx_pkg.sv ----
// Shared constants and types of the serial video transmit output control.
// Assumes a 25 MHz system clock and 32-bit AHB-Lite register access.
package csi_tx_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] CTRL_IDX = 8'h33;
   localparam logic [7:0] CTRL2_IDX = 8'h34;
   localparam logic [7:0] DUP_IDX = 8'h3E;
   localparam logic [7:0] STAT_IDX = 8'h3F;

   // Fields of serial_output_control
   localparam int EN_BIT = 0;
   localparam int CONT_BIT = 1;
   localparam int ULP_LSB = 2;
   localparam int LANE_LSB = 4;
   localparam int CALEN_BIT = 6;
   localparam logic [6:0] CTRL_RESET = 7'h00;

   // Fields of the second control register
   localparam int PER_BIT = 0;
   localparam int SINGLE_BIT = 1;
   localparam int INV_BIT = 2;
   localparam logic [3:0] CTRL2_RSVD = 4'h4;

   // Fields of the duplication register
   localparam int DUP_BIT = 0;

   // Low-power force codes
   localparam logic [1:0] ULP_NORMAL = 2'h0;
   localparam logic [1:0] ULP_DATA = 2'h1;
   localparam logic [1:0] ULP_ALL = 2'h3;

   // Lane count codes
   localparam logic [1:0] LANE_FOUR = 2'h0;
   localparam logic [1:0] LANE_TWO = 2'h2;
   localparam logic [3:0] LANE_ALL = 4'hF;

   // Skew pattern, first bit sent is the MSB
   localparam logic [7:0] CAL_PAT = 8'h55;
   localparam logic [7:0] CAL_PAT_INV = 8'hAA;
   localparam logic [7:0] CAL_LAST = 8'h0F;

   // Stream word: [9] packet start, [8] frame end, [7:0] byte
   localparam int STREAM_W = 10;
   localparam int START_BIT = 9;
   localparam int FE_BIT = 8;

   typedef enum logic [4:0] {
      ST_OFF = 5'h01,
      ST_INIT_CAL = 5'h02,
      ST_IDLE = 5'h04,
      ST_DATA = 5'h08,
      ST_CAL = 5'h10
   } tx_state_e;

endpackage

// ---- rtl/link_sampler.sv ----
// Samples the outside link clock and marks each of its rising edges.
// Assumes the link clock is slower than a third of the system clock.
`timescale 1ns/10ps
module link_sampler (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic link_clk,
   output logic tick
);
   logic meta_ff;
   logic sync_ff;
   logic prev_ff;
   logic tick_ff;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         prev_ff <= 1'b0;
         tick_ff <= 1'b0;
      end else begin
         meta_ff <= link_clk;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
         tick_ff <= sync_ff && !prev_ff;
      end
   end

   assign tick = tick_ff;
endmodule

// ---- rtl/pair_buffer.sv ----
// Two-entry word buffer with valid and ready on both sides.
// Assumes the reader may stall at any time; ready comes from a flip-flop.
`timescale 1ns/10ps
module pair_buffer (
   input wire logic clk,
   input wire logic reset_n,
   stream_if.sink wr,
   stream_if.source rd
);
   logic [csi_tx_pkg::STREAM_W-1:0] mem_ff [2];
   logic wptr_ff;
   logic rptr_ff;
   logic [1:0] count_ff;
   logic rdy_ff;
   logic push;
   logic pop;
   logic [1:0] nxt_count;

   assign push = wr.valid && rdy_ff;
   assign pop = rd.valid && rd.ready;
   assign nxt_count = 2'(count_ff + {1'b0, push} - {1'b0, pop});
   assign wr.ready = rdy_ff;
   assign rd.valid = (count_ff != 2'h0);
   assign rd.data = mem_ff[rptr_ff];

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_ff <= 2'h0;
         rdy_ff <= 1'b1;
         wptr_ff <= 1'b0;
         rptr_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         rdy_ff <= (nxt_count != 2'h2);
         wptr_ff <= wptr_ff ^ push;
         rptr_ff <= rptr_ff ^ pop;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wptr_ff] <= wr.data;
      end
   end

   a_buf_bound: assert property (@(posedge clk) disable iff (!reset_n)
      count_ff != 2'h3) else $error("buffer count out of range");
   a_buf_stall: assert property (@(posedge clk) disable iff (!reset_n)
      rd.valid && !rd.ready |=> rd.valid && $stable(rd.data))
      else $error("stalled word changed or vanished");
   c_buf_full: cover property (@(posedge clk) disable iff (!reset_n) !rdy_ff);
endmodule

// ---- rtl/stream_if.sv ----
// Valid/ready word stream between the transmit control and its buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface stream_if;
   logic valid;
   logic ready;
   logic [csi_tx_pkg::STREAM_W-1:0] data;

   modport sink (input valid, input data, output ready);
   modport source (output valid, output data, input ready);
endinterface
